// *** logic/bbs_unit.sv ***
// Execution unit for bit branches, skips and CPU control instructions
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bbs_unit (
  input  wire logic        core_clk,         // CPU clock, 100 MHz
  input  wire logic        arst_n,           // Async reset, active low
  input  wire logic [3:0]  avs_address,      // Byte address
  input  wire logic        avs_read,         // Read strobe
  input  wire logic        avs_write,        // Write strobe
  input  wire logic [31:0] avs_writedata,    // Write data
  input  wire logic [3:0]  avs_byteenable,   // Byte enables
  output logic      [31:0] avs_readdata,     // Read data
  output logic             avs_waitrequest,  // Stall
  output logic      [7:0]  program_status_word, // Flag word
  output logic             hold_req,         // Clock-hold standby request
  output logic             deep_req,         // Deep standby request
  output logic             skip_next         // Suppress next instruction
);
  import bbs_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } st_e;

  st_e         st_q;
  logic [31:0] insn_q;
  logic [31:0] opnd_q;
  logic [19:0] pc_q;
  logic [7:0]  flags_q;
  logic [7:0]  opbyte_q;
  logic [4:0]  cnt_q;
  logic [4:0]  cyc_q;
  logic        taken_q;

  wire op_e   op    = op_e'(insn_q[INSN_OP_LSB +: 4]);
  wire form_e form  = form_e'(insn_q[INSN_FORM_LSB +: 3]);
  wire [2:0]  bitn  = insn_q[INSN_BIT_LSB +: 3];
  wire [7:0]  disp  = insn_q[INSN_DISP_LSB +: 8];
  wire        ram_f = insn_q[INSN_RAM_BIT];
  wire        flash = opnd_q[OPND_FLASH_BIT];

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic [2:0] insn_len(input op_e o, input form_e f);
    unique case (o)
      OP_BIT_LOW, OP_BIT_CLR:
        insn_len = (f == FORM_ACC || f == FORM_PTR) ? LEN_BIT_SHORT
                                                     : LEN_BIT_LONG;
      OP_INT_ALLOW, OP_INT_BLOCK: insn_len = LEN_INT;
      OP_NULL:              insn_len = LEN_NULL;
      OP_BANK, OP_HOLD, OP_DEEP: insn_len = LEN_CTRL2;
      default:              insn_len = LEN_SKIP;
    endcase
  endfunction

  function automatic logic [4:0] base_cycles(input op_e o, input form_e f,
                                             input logic fl, input logic t);
    logic seg;
    seg = (f == FORM_SEG);
    unique case (o)
      OP_BIT_LOW, OP_BIT_CLR: begin
        if (seg && fl && o == OP_BIT_LOW)
          base_cycles = t ? CYC_SEG_FL_YES : CYC_SEG_FL_NO;
        else if (f == FORM_PTR && fl && o == OP_BIT_LOW)
          base_cycles = t ? CYC_PTR_FL_YES : CYC_PTR_FL_NO;
        else if (seg)
          base_cycles = t ? CYC_SEG_YES : CYC_SEG_NO;
        else
          base_cycles = t ? CYC_BR_YES : CYC_BR_NO;
      end
      OP_INT_ALLOW, OP_INT_BLOCK: base_cycles = CYC_INT;
      OP_HOLD, OP_DEEP:     base_cycles = CYC_STANDBY;
      default:              base_cycles = CYC_ONE;
    endcase
  endfunction

  // Bit under test, taken from operand byte or flag word
  wire [7:0] src_byte = (form == FORM_FLAGS) ? flags_q : opbyte_q;
  wire       tbit     = src_byte[bitn];
  wire       z_f      = flags_q[FLG_ZERO_BIT];
  wire       carry_f  = flags_q[FLG_CARRY_BIT];

  logic cond;
  always_comb begin
    unique case (op)
      OP_BIT_LOW:  cond = ~tbit;
      OP_BIT_CLR:  cond = tbit;
      OP_SKIP_C1:  cond = carry_f;
      OP_SKIP_C0:  cond = ~carry_f;
      OP_SKIP_Z1:  cond = z_f;
      OP_SKIP_Z0:  cond = ~z_f;
      OP_SKIP_HI:  cond = ~(z_f | carry_f);
      OP_SKIP_NHI: cond = z_f | carry_f;
      default:     cond = 1'b0;
    endcase
  end

  wire       is_br  = (op == OP_BIT_LOW) || (op == OP_BIT_CLR);
  wire       is_sk  = (op >= OP_SKIP_C1) && (op <= OP_SKIP_NHI);
  wire [4:0] cyc0   = base_cycles(op, form, flash, cond);
  // RAM fetch worst case: twice the count plus three
  wire [4:0] cyc_d  = ram_f ? 5'((cyc0 << 1) + CYC_RAM_EXTRA) : cyc0;
  wire [19:0] seq_pc = pc_q + 20'(insn_len(op, form));
  wire [19:0] br_pc  = seq_pc + {{12{disp[7]}}, disp};

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  wire busy     = st_q != ST_IDLE;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else if (!rst_n_q) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      // Instruction writes wait while a prior one executes
      avs_waitrequest <= avs_write && avs_address == REG_INSN && busy;
      unique case (avs_address)
        REG_INSN:    avs_readdata <= insn_q;
        REG_OPERAND: avs_readdata <= opnd_q;
        REG_STATUS:  avs_readdata <= {19'h0, cyc_q, flags_q};
        REG_PC:      avs_readdata <= {12'h0, pc_q};
        default:     avs_readdata <= 32'h0;
      endcase
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  wire acc_ok = !avs_waitrequest && (avs_read || avs_write);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 5'h0;
      cyc_q   <= 5'h0;
      taken_q <= 1'b0;
      insn_q  <= 32'h0;
    end else if (!rst_n_q) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 5'h0;
    end else begin
      unique case (st_q)
        ST_IDLE: if (acc_ok && avs_write && avs_address == REG_INSN) begin
          insn_q <= avs_writedata;
          st_q   <= ST_EXEC;
        end
        ST_EXEC: begin
          taken_q <= cond;
          cyc_q   <= cyc_d;
          cnt_q   <= cyc_d - 5'h1;
          st_q    <= (cyc_d == CYC_ONE) ? ST_IDLE : ST_DONE;
        end
        ST_DONE: begin
          cnt_q <= cnt_q - 5'h1;
          if (cnt_q == 5'h1)
            st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Architectural state
  // ****************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      opnd_q   <= 32'h0;
      opbyte_q <= 8'h0;
    end else if (acc_ok && avs_write && avs_address == REG_OPERAND) begin
      opnd_q   <= avs_writedata;
      opbyte_q <= avs_writedata[OPND_BYTE_LSB +: 8];
    end else if (st_q == ST_EXEC && op == OP_BIT_CLR && cond &&
                 form != FORM_FLAGS) begin
      opbyte_q <= opbyte_q & ~(8'h1 << bitn);
      opnd_q[OPND_BYTE_LSB +: 8] <= opbyte_q & ~(8'h1 << bitn);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_q <= PC_RST;
    end else if (st_q == ST_IDLE && acc_ok && avs_write &&
                 avs_address == REG_OPERAND) begin
      pc_q <= avs_writedata[OPND_PC_LSB +: 20];
    end else if (st_q == ST_EXEC) begin
      pc_q <= (is_br && cond) ? br_pc : seq_pc;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= FLAGS_RST;
    end else if (acc_ok && avs_write && avs_address == REG_STATUS) begin
      flags_q <= avs_writedata[7:0];
    end else if (st_q == ST_EXEC) begin
      unique case (op)
        OP_BIT_CLR: if (cond && form == FORM_FLAGS)
          flags_q[bitn] <= 1'b0;
        OP_BANK: begin
          flags_q[FLG_BANK1_BIT] <= bitn[1];
          flags_q[FLG_BANK0_BIT] <= bitn[0];
        end
        OP_INT_ALLOW: flags_q[FLG_INT_EN_BIT] <= 1'b1;
        OP_INT_BLOCK: flags_q[FLG_INT_EN_BIT] <= 1'b0;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_req            <= 1'b0;
      deep_req            <= 1'b0;
      skip_next           <= 1'b0;
      program_status_word <= FLAGS_RST;
    end else begin
      program_status_word <= flags_q;
      if (st_q == ST_EXEC) begin
        hold_req  <= op == OP_HOLD;
        deep_req  <= op == OP_DEEP;
        skip_next <= is_sk && cond;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_exec_clr;
    st_q == ST_EXEC && op == OP_BIT_CLR && cond && form != FORM_FLAGS;
  endsequence

  a_branch_low_pc: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    st_q == ST_EXEC && op == OP_BIT_LOW && !tbit |=> pc_q == $past(br_pc))
    else $error("bit-low branch target wrong");
  a_clear_bit: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    s_exec_clr |=> opbyte_q[$past(bitn)] == 1'b0)
    else $error("test-and-clear left bit set");
  a_cycles_pair: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    st_q == ST_EXEC && is_br && !ram_f && form == FORM_SADDR
    |=> cyc_q == (taken_q ? CYC_BR_YES : CYC_BR_NO))
    else $error("branch cycle count wrong");
  a_skip_carry: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    st_q == ST_EXEC && op == OP_SKIP_C1 |=> skip_next == $past(carry_f))
    else $error("carry skip wrong");
  a_skip_high: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    st_q == ST_EXEC && op == OP_SKIP_HI
    |=> skip_next == !$past(z_f | carry_f))
    else $error("higher skip wrong");
  a_int_allow: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    st_q == ST_EXEC && op == OP_INT_ALLOW && !ram_f
    |=> flags_q[FLG_INT_EN_BIT] ##0
    (st_q == ST_DONE)[*3] ##1 st_q == ST_IDLE)
    else $error("interrupt allow wrong");
  a_int_block: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    st_q == ST_EXEC && op == OP_INT_BLOCK |=> !flags_q[FLG_INT_EN_BIT])
    else $error("interrupt block wrong");
  a_bank_field: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    st_q == ST_EXEC && op == OP_BANK
    |=> {flags_q[FLG_BANK1_BIT], flags_q[FLG_BANK0_BIT]} == $past(bitn[1:0]))
    else $error("bank select wrong");
  a_null_keeps: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    st_q == ST_EXEC && op == OP_NULL |=> $stable(flags_q) &&
    pc_q == $past(pc_q) + 20'h1)
    else $error("null instruction changed state");

endmodule
`default_nettype wire

// *** pkg/bbs_pkg.sv ***
// Package: opcodes, forms, lengths and cycle counts of the bit-branch unit
package bbs_pkg;

  // ****************************************************************
  // Register map (Avalon-MM, word aligned byte addresses)
  // ****************************************************************
  localparam logic [3:0] REG_INSN     = 4'h0; // Write launches
  localparam logic [3:0] REG_OPERAND  = 4'h4; // Bit operand / flash flag
  localparam logic [3:0] REG_STATUS   = 4'h8; // Cycle count, flag word
  localparam logic [3:0] REG_PC       = 4'hc; // Next program counter
  localparam logic [3:0] REG_CONTROL  = 4'h0; // Unused alias guard

  // Field positions of REG_INSN
  localparam int INSN_OP_LSB    = 0;  // 4-bit operation
  localparam int INSN_FORM_LSB  = 4;  // 3-bit addressing form
  localparam int INSN_BIT_LSB   = 8;  // 3-bit bit number / bank n
  localparam int INSN_DISP_LSB  = 16; // 8-bit displacement
  localparam int INSN_RAM_BIT   = 24; // Fetched from internal RAM

  // Field positions of REG_OPERAND
  localparam int OPND_BYTE_LSB  = 0;  // Operand byte of the bit form
  localparam int OPND_FLASH_BIT = 8;  // Operand lies in flash
  localparam int OPND_PC_LSB    = 12; // Current PC (20 bits)

  // Reset values
  localparam logic [19:0] PC_RST   = 20'h00000;
  localparam logic [7:0]  FLAGS_RST = 8'h06;

  // Flag word bit positions
  localparam int FLG_INT_EN_BIT = 7;
  localparam int FLG_ZERO_BIT   = 6;
  localparam int FLG_BANK1_BIT  = 5;
  localparam int FLG_HALF_BIT   = 4;
  localparam int FLG_BANK0_BIT  = 3;
  localparam int FLG_CARRY_BIT  = 0;

  typedef enum logic [3:0] {
    OP_NULL      = 4'h0,
    OP_BIT_LOW   = 4'h1,
    OP_BIT_CLR   = 4'h2,
    OP_SKIP_C1   = 4'h3,
    OP_SKIP_C0   = 4'h4,
    OP_SKIP_Z1   = 4'h5,
    OP_SKIP_Z0   = 4'h6,
    OP_SKIP_HI   = 4'h7,
    OP_SKIP_NHI  = 4'h8,
    OP_BANK      = 4'h9,
    OP_INT_ALLOW = 4'ha,
    OP_INT_BLOCK = 4'hb,
    OP_HOLD      = 4'hc,
    OP_DEEP      = 4'hd
  } op_e;

  typedef enum logic [2:0] {
    FORM_SADDR = 3'h0,
    FORM_SFR   = 3'h1,
    FORM_ACC   = 3'h2,
    FORM_FLAGS = 3'h3,
    FORM_PTR   = 3'h4,
    FORM_SEG   = 3'h5
  } form_e;

  // Instruction lengths in bytes
  localparam logic [2:0] LEN_BIT_LONG  = 3'h4;
  localparam logic [2:0] LEN_BIT_SHORT = 3'h3;
  localparam logic [2:0] LEN_SKIP      = 3'h2;
  localparam logic [2:0] LEN_CTRL2     = 3'h2;
  localparam logic [2:0] LEN_INT       = 3'h3;
  localparam logic [2:0] LEN_NULL      = 3'h1;

  // Cycle counts (not met / met)
  localparam logic [4:0] CYC_BR_NO      = 5'h03;
  localparam logic [4:0] CYC_BR_YES     = 5'h05;
  localparam logic [4:0] CYC_SEG_NO     = 5'h04;
  localparam logic [4:0] CYC_SEG_YES    = 5'h06;
  localparam logic [4:0] CYC_PTR_FL_NO  = 5'h06;
  localparam logic [4:0] CYC_PTR_FL_YES = 5'h07;
  localparam logic [4:0] CYC_SEG_FL_NO  = 5'h07;
  localparam logic [4:0] CYC_SEG_FL_YES = 5'h08;
  localparam logic [4:0] CYC_ONE        = 5'h01;
  localparam logic [4:0] CYC_INT        = 5'h04;
  localparam logic [4:0] CYC_STANDBY    = 5'h03;
  localparam logic [4:0] CYC_RAM_EXTRA  = 5'h03;

  typedef struct packed {
    logic [19:0] pc;
    logic        skip;
    logic        wr_bit;
    logic [7:0]  wr_byte;
  } result_s;

endpackage

// *** testbench/bit_branch_skip_cpu_control_tb.sv ***
// Self-checking bench for the bit-branch, skip and CPU control unit
`timescale 1ns/1ps
`default_nettype none
module bit_branch_skip_cpu_control_tb;
  import bbs_pkg::*;

  logic        core_clk;
  logic        arst_n;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  flags;
  logic        hold_req;
  logic        deep_req;
  logic        skip_next;
  int          mismatches;
  int          checked;

  bbs_unit u_dut (
    .core_clk            (core_clk),
    .arst_n              (arst_n),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_byteenable      (4'hf),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .program_status_word (flags),
    .hold_req            (hold_req),
    .deep_req            (deep_req),
    .skip_next           (skip_next)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 60);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 60) begin
      mismatches++;
      stop_test();
    end
  endtask

  // ****************************************************************
  // One instruction: expectation worked out, then run and compared
  // ****************************************************************
  task automatic run_one(input logic [3:0] op, input logic [2:0] form,
                         input logic [2:0] bn, input logic [7:0] disp,
                         input logic ram, input logic fl,
                         input logic [7:0] byt, input logic [7:0] fw,
                         input logic [19:0] pc);
    logic [19:0] epc;
    logic [7:0]  efw;
    logic [7:0]  ebyt;
    logic [4:0]  ecyc;
    logic [2:0]  len;
    logic        eskip;
    logic        src;
    logic        bitop;
    logic        taken;
    logic [31:0] rd;
    efw   = fw;
    ebyt  = byt;
    eskip = 1'b0;
    bitop = (op == OP_BIT_LOW) || (op == OP_BIT_CLR);
    src   = (form == FORM_FLAGS) ? fw[bn] : byt[bn];
    taken = bitop && ((op == OP_BIT_LOW) ? !src : src);
    if (bitop) begin
      len = (form == FORM_ACC || form == FORM_PTR) ? 3'h3 : 3'h4;
    end else if (op == OP_NULL) begin
      len = 3'h1;
    end else if (op == OP_INT_ALLOW || op == OP_INT_BLOCK) begin
      len = 3'h3;
    end else begin
      len = 3'h2;
    end
    if (bitop && form == FORM_SEG) begin
      if (fl && op == OP_BIT_LOW) ecyc = taken ? 5'h08 : 5'h07;
      else ecyc = taken ? 5'h06 : 5'h04;
    end else if (bitop && form == FORM_PTR && fl && op == OP_BIT_LOW) begin
      ecyc = taken ? 5'h07 : 5'h06;
    end else if (bitop) begin
      ecyc = taken ? 5'h05 : 5'h03;
    end else if (op == OP_INT_ALLOW || op == OP_INT_BLOCK) begin
      ecyc = 5'h04;
    end else if (op == OP_HOLD || op == OP_DEEP) begin
      ecyc = 5'h03;
    end else begin
      ecyc = 5'h01;
    end
    if (ram) ecyc = 5'(2 * ecyc + 3);
    epc = pc + 20'(len) + (taken ? {{12{disp[7]}}, disp} : 20'h0);
    case (op)
      4'h3: eskip = fw[0];
      4'h4: eskip = !fw[0];
      4'h5: eskip = fw[6];
      4'h6: eskip = !fw[6];
      4'h7: eskip = !(fw[6] | fw[0]);
      4'h8: eskip = fw[6] | fw[0];
      default: eskip = 1'b0;
    endcase
    if (op == OP_BANK) begin
      efw[5] = bn[1];
      efw[3] = bn[0];
    end
    if (op == OP_INT_ALLOW) efw[7] = 1'b1;
    if (op == OP_INT_BLOCK) efw[7] = 1'b0;
    if (op == OP_BIT_CLR && taken) begin
      if (form == FORM_FLAGS) efw[bn] = 1'b0;
      else ebyt[bn] = 1'b0;
    end
    bus(1'b1, REG_STATUS, {24'h0, fw}, rd);
    bus(1'b1, REG_OPERAND, {pc, 3'h0, fl, byt}, rd);
    bus(1'b1, REG_INSN, {7'h0, ram, disp, 5'h0, bn, 1'b0, form, op}, rd);
    // Longest instruction is 2*8+3 clocks; let it finish
    repeat (22) @(posedge core_clk);
    chk("skip_next", {31'h0, skip_next}, {31'h0, eskip});
    chk("hold_req", {31'h0, hold_req}, {31'h0, op == OP_HOLD});
    chk("deep_req", {31'h0, deep_req}, {31'h0, op == OP_DEEP});
    chk("flags", {24'h0, flags}, {24'h0, efw});
    bus(1'b0, REG_PC, 32'h0, rd);
    chk("pc", {12'h0, rd[19:0]}, {12'h0, epc});
    bus(1'b0, REG_STATUS, 32'h0, rd);
    chk("cycles", {27'h0, rd[12:8]}, {27'h0, ecyc});
    bus(1'b0, REG_OPERAND, 32'h0, rd);
    chk("operand", {24'h0, rd[7:0]}, {24'h0, ebyt});
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] rd;
    logic [7:0]  byt;
    logic [7:0]  fw;
    logic [7:0]  disp;
    logic [19:0] pc;
    logic [2:0]  bn;
    int          nform;
    mismatches    = 0;
    checked       = 0;
    arst_n        = 1'b0;
    avs_address   = 4'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    void'($urandom(1896));
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("reset flags", {24'h0, flags}, 32'h00000006);
    chk("reset hold", {31'h0, hold_req}, 32'h0);
    chk("reset deep", {31'h0, deep_req}, 32'h0);
    bus(1'b0, REG_PC, 32'h0, rd);
    chk("reset pc", {12'h0, rd[19:0]}, 32'h0);
    bus(1'b1, 4'h6, 32'hffffffff, rd);
    bus(1'b0, 4'h2, 32'h0, rd);
    chk("unmapped read", rd, 32'h0);
    bus(1'b0, REG_STATUS, 32'h0, rd);
    chk("flags after unmapped write", {24'h0, rd[7:0]}, 32'h00000006);
    for (int p = 0; p < 4; p++) begin
      for (int op = 0; op < 14; op++) begin
        nform = (op == 1 || op == 2) ? 6 : 1;
        for (int f = 0; f < nform; f++) begin
          bn   = 3'($urandom);
          byt  = 8'($urandom);
          fw   = 8'($urandom);
          disp = (p == 0) ? 8'h80 : (p == 1) ? 8'h7f : 8'($urandom);
          pc   = (p == 2) ? 20'hffffe : 20'($urandom);
          byt[bn] = p[0];
          fw[bn]  = p[0];
          if (op == 9) bn[2] = 1'b0;
          run_one(4'(op), 3'(f), bn, disp, 1'($urandom), 1'($urandom),
                  byt, fw, pc);
        end
      end
    end
    stop_test();
  end
endmodule
`default_nettype wire
